// >>> core/clip_copro.sv
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module clip_copro
  import clip_ops_pkg::*;
#(
  parameter logic [2:0] COPRO_SEL = 3'h0 // arbitrary selector value
)
(
  input wire logic pclk,
  input wire logic presetn,
  copro_link_if.device link,
  input wire logic [4:0] peek_sel,
  output logic [31:0] peek_data,
  output logic busy
);
  typedef enum logic [2:0]
  {
    D_IDLE, D_LOAD1, D_LOAD2, D_CLIP1, D_CLIP2, D_CLIP3, D_CLIP4
  } dev_state_t;

  typedef struct packed
  {
    dev_state_t st;
    logic [FILE_DEPTH-1:0][31:0] fa;
    logic [FILE_DEPTH-1:0][31:0] fb;
    logic [31:0] c;
    logic [31:0] ct;
    logic [3:0] flags;
    logic [31:0] word;
    logic [1:0] fmt;
    logic done;
    logic fault;
    logic [31:0] peek;
  } dev_regs_t;

  dev_regs_t r_reg;
  dev_regs_t r_next;

  // flags of a minus b: N, Z, borrow, overflow
  function automatic logic [3:0] sub_flags(input logic [31:0] a,
                                           input logic [31:0] b);
    logic [32:0] d;
    d = {1'b0, a} - {1'b0, b};
    return {d[31], d[31:0] == 32'h00000000, d[32],
            (a[31] != b[31]) && (d[31] != a[31])};
  endfunction

  // low word of a signed product
  function automatic logic [31:0] mul_lo(input logic [31:0] a,
                                         input logic [31:0] b);
    logic [63:0] p;
    p = 64'($signed(a) * $signed(b));
    return p[31:0];
  endfunction

  // typed zero of the selected format; all three encode as all-zero bits
  function automatic logic [31:0] typed_zero(input logic [1:0] fmt);
    logic [31:0] z;
    case (fmt)
      FMT_INT: z = 32'h00000000;
      FMT_SINGLE: z = 32'h00000000;
      default: z = 32'h00000000;
    endcase
    return z;
  endfunction

  // next state of the whole coprocessor
  always_comb
  begin
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] di;
    logic [31:0] dq;
    logic [31:0] w_in;
    op_t op;
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.fault = 1'b0;
    w_in = link.cmd_word;
    op = decode_op(w_in);
    s1 = r_reg.word[SRC1_MSB:SRC1_LSB];
    s2 = r_reg.word[SRC2_MSB:SRC2_LSB];
    di = r_reg.word[19:16];
    dq = 32'h00000000;
    case (r_reg.st)
      D_IDLE:
        if (link.cmd_valid)
        begin
          r_next.word = w_in;
          r_next.fmt = {w_in[T_BIT], w_in[S_BIT]};
          if (w_in[SEL_MSB:SEL_LSB] != COPRO_SEL)
            r_next.fault = 1'b1;
          else
            case (op)
              OP_CLIP: r_next.st = D_CLIP1;
              OP_CLR: r_next.st = D_CLIP4;
              OP_CMP_REG:
              begin
                r_next.flags = sub_flags(
                  r_reg.fa[w_in[SRC1_MSB:SRC1_LSB]],
                  r_reg.fb[w_in[SRC2_MSB:SRC2_LSB]]);
                r_next.done = 1'b1;
              end
              OP_CMP_HOST:
                if (w_in[S_BIT])
                  r_next.fault = 1'b1;
                else
                  r_next.st = D_LOAD1;
              OP_CMP_MEM: r_next.st = D_LOAD1;
              default: r_next.fault = 1'b1;
            endcase
        end
      D_LOAD1:
        if (link.xfer_valid)
        begin
          r_next.fa[s1] = link.xfer_data;
          r_next.st = D_LOAD2;
        end
      D_LOAD2:
        if (link.xfer_valid)
        begin
          // the second operand is taken straight from the link, so fb and the flags move on the same edge
          r_next.fb[s2] = link.xfer_data;
          r_next.flags = sub_flags(r_reg.fa[s1], link.xfer_data);
          r_next.done = 1'b1;
          r_next.st = D_IDLE;
        end
      D_CLIP1:
      begin
        r_next.c = r_reg.fa[2];
        r_next.ct = r_reg.fb[2];
        r_next.flags[FLAG_N] = r_reg.fa[2][31];
        if (r_reg.fa[2][31])
        begin
          r_next.fb[8] = r_reg.fa[3] + r_reg.fa[2];
          r_next.fa[8] = r_reg.fb[3] + r_reg.fb[2];
        end
        else
        begin
          r_next.fb[8] = r_reg.fa[3] - r_reg.fa[2];
          r_next.fa[8] = r_reg.fb[3] - r_reg.fb[2];
        end
        r_next.st = D_CLIP2;
      end
      D_CLIP2:
      begin
        r_next.fb[9] = r_reg.fa[0] - r_reg.fb[0];
        r_next.fb[8] = r_reg.fa[8] - r_reg.fb[8];
        r_next.fa[9] = r_reg.fa[1] - r_reg.fb[1];
        r_next.st = D_CLIP3;
      end
      D_CLIP3:
      begin
        // a zero denominator leaves t at zero instead of trapping
        if (r_reg.fb[8] == 32'h00000000)
          r_next.c = 32'h00000000;
        else
          r_next.c = 32'($signed(r_reg.fa[8]) / $signed(r_reg.fb[8]));
        r_next.fa[8] = r_reg.fa[2] - r_reg.fb[2];
        r_next.st = D_CLIP4;
      end
      D_CLIP4:
      begin
        if (decode_op(r_reg.word) == OP_CLR)
        begin
          dq = typed_zero(r_reg.fmt);
          if (di == SEL_C)
            r_next.c = dq;
          else if (di == SEL_CT)
            r_next.ct = dq;
          else if (di < 4'(FILE_DEPTH) && r_reg.word[DEST_FILE_BIT])
            r_next.fb[di] = dq;
          else if (di < 4'(FILE_DEPTH))
            r_next.fa[di] = dq;
          r_next.flags[FLAG_Z] = 1'b1;
        end
        else
        begin
          // X2' Y2' Z2' W2' overwrite the first endpoint
          r_next.fa[0] = mul_lo(r_reg.fb[9], r_reg.c) + r_reg.fb[0];
          r_next.fa[1] = mul_lo(r_reg.fa[9], r_reg.c) + r_reg.fb[1];
          r_next.fa[2] = mul_lo(r_reg.fa[8], r_reg.c) + r_reg.fb[2];
          r_next.fa[9] = r_reg.fa[3] - r_reg.fb[3];
          r_next.ct = mul_lo(r_reg.fa[3] - r_reg.fb[3], r_reg.c);
          r_next.fa[3] = r_next.ct + r_reg.fb[3];
        end
        r_next.done = 1'b1;
        r_next.st = D_IDLE;
      end
      default: r_next.st = D_IDLE;
    endcase
    // register peek for software visibility
    if (peek_sel[3:0] == SEL_C)
      r_next.peek = r_reg.c;
    else if (peek_sel[3:0] == SEL_CT)
      r_next.peek = r_reg.ct;
    else if (peek_sel[3:0] >= 4'(FILE_DEPTH))
      r_next.peek = 32'h00000000;
    else if (peek_sel[4])
      r_next.peek = r_reg.fb[peek_sel[3:0]];
    else
      r_next.peek = r_reg.fa[peek_sel[3:0]];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  // ready strobes follow the state, results come from flops
  assign link.cmd_ready = (r_reg.st == D_IDLE);
  assign link.xfer_ready = (r_reg.st == D_LOAD1) || (r_reg.st == D_LOAD2);
  assign link.done = r_reg.done;
  assign link.fault = r_reg.fault;
  assign link.flags = r_reg.flags;
  assign peek_data = r_reg.peek;
  assign busy = (r_reg.st != D_IDLE);
endmodule
`default_nettype wire

// >>> core/clip_ops_pkg.sv
package clip_ops_pkg;
  // coprocessor word fields
  localparam int SEL_MSB = 31;
  localparam int SEL_LSB = 29;
  localparam int SRC1_MSB = 28;
  localparam int SRC1_LSB = 25;
  localparam int SRC2_MSB = 24;
  localparam int SRC2_LSB = 21;
  localparam int DEST_MSB = 20;
  localparam int DEST_LSB = 16;
  localparam int DEST_FILE_BIT = 20;
  localparam int CLASS_MSB = 15;
  localparam int CLASS_LSB = 12;
  localparam int OPC_MSB = 11;
  localparam int OPC_LSB = 9;
  localparam int T_BIT = 8;
  localparam int S_BIT = 7;
  // fixed field patterns
  localparam logic [3:0] CLIP_CLASS = 4'h2;
  localparam logic [2:0] CLIP_OPC = 3'h6;
  localparam logic [3:0] CLIP_HI_NIB = 4'h2;
  localparam logic [3:0] CLR_SRC = 4'hD;
  localparam logic [3:0] CLR_CLASS = 4'h0;
  localparam logic [2:0] CLR_OPC = 3'h1;
  localparam logic [2:0] CMP_OPC = 3'h2;
  localparam logic [3:0] CMP_REG_CLASS = 4'h0;
  localparam logic [3:0] CMP_HOST_CLASS = 4'h4;
  localparam logic [3:0] CMP_MEM_CLASS = 4'h8;
  localparam logic [4:0] CMP_PAD = 5'h00;
  // format select {t,s}
  localparam logic [1:0] FMT_INT = 2'h0;
  localparam logic [1:0] FMT_SINGLE = 2'h2;
  localparam logic [1:0] FMT_DOUBLE = 2'h3;
  // register file sizes and special selectors
  localparam int FILE_DEPTH = 10;
  localparam logic [3:0] SEL_C = 4'hA;
  localparam logic [3:0] SEL_CT = 4'hB;
  // status flag positions
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_C = 1;
  localparam int FLAG_V = 0;
  // host pointer step per memory load
  localparam logic [31:0] PTR_STEP = 32'h00000020;
  // host controller register offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_OPA = 8'h04;
  localparam logic [7:0] OFS_OPB = 8'h08;
  localparam logic [7:0] OFS_PTR = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam int STAT_DONE = 0;
  localparam int STAT_FAULT = 1;
  localparam int STAT_REFUSED = 2;
  localparam logic [31:0] RST_WORD = 32'h00000000;

  typedef enum logic [2:0]
  {
    OP_NONE, OP_CLIP, OP_CLR, OP_CMP_REG, OP_CMP_HOST, OP_CMP_MEM
  } op_t;

  // classify a coprocessor word (selector match checked by caller)
  function automatic op_t decode_op(input logic [31:0] w);
    op_t op;
    op = OP_NONE;
    if (w[CLASS_MSB:CLASS_LSB] == CLIP_CLASS && w[OPC_MSB:OPC_LSB] == CLIP_OPC
        && w[19:16] == CLIP_HI_NIB && w[28:20] == 9'h000)
      op = OP_CLIP;
    else if (w[OPC_MSB:OPC_LSB] == CLR_OPC && w[CLASS_MSB:CLASS_LSB] == CLR_CLASS
        && w[SRC1_MSB:SRC1_LSB] == CLR_SRC && w[SRC2_MSB:SRC2_LSB] == CLR_SRC)
      op = OP_CLR;
    else if (w[OPC_MSB:OPC_LSB] == CMP_OPC && w[DEST_MSB:DEST_LSB] == CMP_PAD)
    begin
      case (w[CLASS_MSB:CLASS_LSB])
        CMP_REG_CLASS: op = OP_CMP_REG;
        CMP_HOST_CLASS: op = OP_CMP_HOST;
        CMP_MEM_CLASS: op = OP_CMP_MEM;
        default: op = OP_NONE;
      endcase
    end
    return op;
  endfunction
endpackage

// >>> core/copro_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// word-level link between the host controller and the coprocessor
interface copro_link_if;
  logic cmd_valid;
  logic cmd_ready;
  logic [31:0] cmd_word;
  logic xfer_valid;
  logic xfer_ready;
  logic [31:0] xfer_data;
  logic done;
  logic fault;
  logic [3:0] flags;
  modport device
  (
    input cmd_valid, cmd_word, xfer_valid, xfer_data,
    output cmd_ready, xfer_ready, done, fault, flags
  );
  modport host
  (
    output cmd_valid, cmd_word, xfer_valid, xfer_data,
    input cmd_ready, xfer_ready, done, fault, flags
  );
endinterface
`default_nettype wire

// >>> core/clip_host.sv
`timescale 1ns/10ps
`default_nettype none
module clip_host
  import clip_ops_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  copro_link_if.host link
);
  typedef enum logic [2:0]
  {
    H_IDLE, H_ISSUE, H_FETCH, H_SEND, H_WAIT
  } host_state_t;

  typedef struct packed
  {
    host_state_t st;
    logic [31:0] cmd;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] ptr;
    logic [31:0] data;
    logic second;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [31:0] rdata;
  } host_regs_t;

  host_regs_t r_reg;
  host_regs_t r_next;

  // controller sequencing plus its register file
  always_comb
  begin
    logic wr;
    logic [2:0] ev;
    op_t op;
    r_next = r_reg;
    ev = 3'h0;
    wr = psel && penable && pwrite;
    op = decode_op(r_reg.cmd);
    case (r_reg.st)
      H_IDLE: ;
      H_ISSUE:
        if (link.cmd_ready)
        begin
          r_next.second = 1'b0;
          r_next.data = r_reg.opa;
          if (op == OP_CMP_MEM)
            r_next.st = H_FETCH;
          else if (op == OP_CMP_HOST)
            r_next.st = H_SEND;
          else
            r_next.st = H_WAIT;
        end
      H_FETCH:
        if (link.fault)
        begin
          ev[STAT_FAULT] = 1'b1;
          r_next.st = H_IDLE;
        end
        else if (mem_ack)
        begin
          r_next.data = mem_rdata;
          r_next.ptr = r_reg.ptr + PTR_STEP;
          r_next.st = H_SEND;
        end
      H_SEND:
        if (link.fault)
        begin
          ev[STAT_FAULT] = 1'b1;
          r_next.st = H_IDLE;
        end
        else if (link.xfer_ready)
        begin
          r_next.second = 1'b1;
          if (r_reg.second)
            r_next.st = H_WAIT;
          else if (op == OP_CMP_MEM)
            r_next.st = H_FETCH;
          else
            r_next.data = r_reg.opb;
        end
      H_WAIT:
        if (link.done || link.fault)
        begin
          ev[STAT_DONE] = link.done;
          ev[STAT_FAULT] = link.fault;
          r_next.st = H_IDLE;
        end
      default: r_next.st = H_IDLE;
    endcase
    // register writes; a command only starts from idle
    if (wr)
      case (paddr)
        OFS_CMD:
          if (r_reg.st != H_IDLE)
            ev[STAT_REFUSED] = 1'b1;
          else if (decode_op(pwdata) == OP_CMP_HOST && pwdata[S_BIT])
            ev[STAT_REFUSED] = 1'b1;
          else
          begin
            r_next.cmd = pwdata;
            r_next.st = H_ISSUE;
          end
        OFS_OPA: r_next.opa = pwdata;
        OFS_OPB: r_next.opb = pwdata;
        OFS_PTR: r_next.ptr = pwdata;
        OFS_STAT: r_next.stat = r_reg.stat & ~pwdata[2:0];
        OFS_MASK: r_next.mask = pwdata[2:0];
        default: ;
      endcase
    // a new event beats a same-cycle clear
    r_next.stat = r_next.stat | ev;
    // read data is captured in the setup cycle
    if (psel && !penable)
      case (paddr)
        OFS_CMD: r_next.rdata = r_reg.cmd;
        OFS_OPA: r_next.rdata = r_reg.opa;
        OFS_OPB: r_next.rdata = r_reg.opb;
        OFS_PTR: r_next.rdata = r_reg.ptr;
        OFS_STAT: r_next.rdata = {29'h00000000, r_reg.stat};
        OFS_MASK: r_next.rdata = {29'h00000000, r_reg.mask};
        OFS_FLAGS: r_next.rdata = {27'h0000000,
                                   r_reg.st != H_IDLE, link.flags};
        default: r_next.rdata = 32'h00000000;
      endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  // the slave never stalls, so every access ends in two cycles
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = r_reg.rdata;
  assign irq = |(r_reg.stat & r_reg.mask);
  assign mem_req = (r_reg.st == H_FETCH);
  assign mem_addr = r_reg.ptr;
  assign link.cmd_valid = (r_reg.st == H_ISSUE);
  assign link.cmd_word = r_reg.cmd;
  assign link.xfer_valid = (r_reg.st == H_SEND);
  assign link.xfer_data = r_reg.data;
endmodule
`default_nettype wire

// >>> verification/clip_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module clip_link_assertions
  import clip_ops_pkg::*;
#(
  parameter logic [2:0] COPRO_SEL = 3'h0 // arbitrary selector value
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [31:0] cmd_word,
  input wire logic xfer_valid,
  input wire logic xfer_ready,
  input wire logic [31:0] xfer_data,
  input wire logic done,
  input wire logic fault,
  input wire logic [3:0] flags
);
  logic take;
  logic xtake;
  logic ok_sel;
  logic [1:0] xcnt_reg;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // handshakes on the link
  assign take = cmd_valid && cmd_ready;
  assign xtake = xfer_valid && xfer_ready;
  assign ok_sel = cmd_word[SEL_MSB:SEL_LSB] == COPRO_SEL;
  // operand words since the last command; restarts on every take
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      xcnt_reg <= 2'h0;
    else if (take)
      xcnt_reg <= 2'h0;
    else if (xtake)
      xcnt_reg <= xcnt_reg + 2'h1;
  end
  AST_CLR_LAT: assert property (take && ok_sel &&
    cmd_word[28:21] == {CLR_SRC, CLR_SRC} &&
    cmd_word[15:9] == {CLR_CLASS, CLR_OPC} |=> !done ##1 done && flags[FLAG_Z])
    else $error("clear did not end with zero flag");
  AST_CMP_LAT: assert property (take && ok_sel &&
    cmd_word[20:9] == {CMP_PAD, CMP_REG_CLASS, CMP_OPC} |=> done && !fault)
    else $error("register compare late");
  AST_CLIP_LAT: assert property (take && ok_sel &&
    cmd_word[28:9] == {9'h000, CLIP_HI_NIB, CLIP_CLASS, CLIP_OPC}
    |=> !done [*4] ##1 done)
    else $error("clip not done after five cycles");
  AST_BAD_SEL: assert property (take && !ok_sel |=> fault && !done)
    else $error("foreign selector not rejected");
  AST_HOST_NO_DBL: assert property (take &&
    cmd_word[15:9] == {CMP_HOST_CLASS, CMP_OPC} |-> !cmd_word[S_BIT])
    else $error("host compare sent in double format");
  AST_SECOND_XFER: assert property (xtake && xcnt_reg == 2'h1
    |=> done && !fault)
    else $error("compare not done after second operand");
  AST_XFER_COUNT: assert property (xtake |-> xcnt_reg < 2'h2)
    else $error("more than two operand words");
  AST_XFER_HOLD: assert property (xfer_valid && !xfer_ready
    |=> xfer_valid && $stable(xfer_data))
    else $error("operand word changed before taken");
endmodule
`default_nettype wire

// >>> verification/test_clip_clear_compare_ops.sv
`timescale 1ns/10ps
`default_nettype none
module test_clip_clear_compare_ops
  import clip_ops_pkg::*;
();
  localparam logic [2:0] SEL = 3'h0; // arbitrary selector value
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic mem_req, busy;
  logic mem_ack = 1'b0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, mem_addr, peek_data, junk;
  logic [31:0] mem_rdata = 32'h00000000;
  logic [4:0] peek_sel;
  logic [31:0] addr_log [$];
  int n_fail = 0;
  int total_checks = 0;
  int busy_cycles = 0;
  copro_link_if link ();
  clip_host u_clip_host (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .link(link));
  clip_copro #(.COPRO_SEL(SEL)) u_clip_copro (.pclk(pclk), .presetn(presetn),
    .link(link), .peek_sel(peek_sel), .peek_data(peek_data), .busy(busy));
  clip_link_assertions #(.COPRO_SEL(SEL)) u_clip_link_assertions (
    .pclk(pclk), .presetn(presetn), .cmd_valid(link.cmd_valid),
    .cmd_ready(link.cmd_ready), .cmd_word(link.cmd_word),
    .xfer_valid(link.xfer_valid), .xfer_ready(link.xfer_ready),
    .xfer_data(link.xfer_data), .done(link.done), .fault(link.fault),
    .flags(link.flags));
  always #4 pclk = ~pclk;
  // memory answers a cycle late with address plus 0x10, so the two
  // operands differ and a swapped pairing shows; idle data toggles
  always @(posedge pclk)
  begin
    mem_ack <= mem_req && !mem_ack;
    mem_rdata <= (mem_req && !mem_ack) ? mem_addr + 32'h00000010 : ~mem_rdata;
    if (mem_req && mem_ack)
      addr_log.push_back(mem_addr);
    if (busy === 1'b1)
      busy_cycles <= busy_cycles + 1; // times the device sequences
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one apb transfer, entered a cycle after the previous release
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20)
    begin
      n_fail++;
      end_sim();
    end
  endtask
  function automatic logic [31:0] word(input logic [3:0] cls,
    input logic [2:0] opc, input logic [3:0] s1, input logic [3:0] s2,
    input logic [4:0] d, input logic [1:0] fmt);
    return {SEL, s1, s2, d, cls, opc, fmt, 7'h00};
  endfunction
  // issue a word, poll the sticky status, then clear it
  task automatic run(input logic [31:0] w, input logic [31:0] exp);
    logic [31:0] s;
    int i;
    apb(1'b1, OFS_CMD, w, s);
    s = 32'h0;
    for (i = 0; i < 40 && s[2:0] === 3'h0; i++)
      apb(1'b0, OFS_STAT, 32'h0, s);
    chk("stat", exp, s);
    if (s[2:0] === 3'h0)
      end_sim();
    apb(1'b1, OFS_STAT, 32'h7, s);
  endtask
  task automatic peek(input string name, input logic [4:0] sel,
    input logic [31:0] exp);
    @(posedge pclk);
    peek_sel <= sel;
    repeat (2) @(posedge pclk);
    chk(name, exp, peek_data);
  endtask
  task automatic rdchk(input string name, input logic [7:0] a,
    input logic [31:0] exp);
    logic [31:0] s;
    apb(1'b0, a, 32'h0, s);
    chk(name, exp, s);
  endtask
  task automatic hload(input logic [3:0] i, input logic [3:0] j,
    input logic [31:0] va, input logic [31:0] vb);
    apb(1'b1, OFS_OPA, va, junk);
    apb(1'b1, OFS_OPB, vb, junk);
    run(word(CMP_HOST_CLASS, CMP_OPC, i, j, 5'h00, FMT_INT), 32'h1);
  endtask
  task automatic t_reset();
    rdchk("flags", OFS_FLAGS, 32'h0);
    rdchk("stat", OFS_STAT, 32'h0);
    rdchk("unmapped", 8'hFC, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    chk("pslverr", 32'h0, {31'h0, pslverr});
    chk("busy", 32'h0, {31'h0, busy});
  endtask
  // clear after a negative compare keeps n and borrow, adds z
  task automatic t_clear();
    logic [1:0] fm [3] = '{FMT_INT, FMT_SINGLE, FMT_DOUBLE};
    logic [4:0] d;
    foreach (fm[k])
    begin
      d = (k == 1) ? 5'h16 : 5'h05;
      hload(4'h5, 4'h6, 32'h3, 32'h7);
      rdchk("cmp flags", OFS_FLAGS, 32'hA);
      run(word(CLR_CLASS, CLR_OPC, CLR_SRC, CLR_SRC, d, fm[k]), 32'h1);
      rdchk("clr flags", OFS_FLAGS, 32'hE);
      peek("cleared", d, 32'h0);
    end
    run(word(CMP_REG_CLASS, CMP_OPC, 4'h5, 4'h6, 5'h00, FMT_SINGLE), 1);
    rdchk("reg cmp flags", OFS_FLAGS, 32'hA);
    peek("a5", 5'h05, 32'h0);
    peek("b6", 5'h16, 32'h7);
    run(word(CMP_HOST_CLASS, CMP_OPC, 4'h5, 4'h6, 5'h00, FMT_DOUBLE), 4);
    // flipping the top bits always gives a selector other than ours
    run(word(CMP_REG_CLASS, CMP_OPC, 4'h5, 4'h6, 5'h0, 2'h0)
      ^ {3'h5, 29'h00000000}, 32'h2);
  endtask
  task automatic t_mem();
    apb(1'b1, OFS_PTR, 32'h00000100, junk);
    run(word(CMP_MEM_CLASS, CMP_OPC, 4'h1, 4'h2, 5'h00, FMT_INT), 1);
    chk("fetches", 32'h2, addr_log.size());
    chk("addr0", 32'h00000100, addr_log[0]);
    chk("addr1", 32'h00000120, addr_log[1]);
    rdchk("ptr", OFS_PTR, 32'h00000140);
    // 0x110 minus 0x130 is negative with a borrow
    rdchk("mem flags", OFS_FLAGS, 32'hA);
    peek("a1", 5'h01, 32'h00000110);
    peek("b2", 5'h12, 32'h00000130);
  endtask
  task automatic t_clip(input logic [127:0] p1, input logic [127:0] p2,
    input logic [127:0] q, input logic [31:0] fl, input logic [31:0] ct);
    int b;
    for (int i = 0; i < 4; i++)
      hload(i[3:0], i[3:0], p1[32*i+:32], p2[32*i+:32]);
    b = busy_cycles;
    run(word(CLIP_CLASS, CLIP_OPC, 4'h0, 4'h0, 5'h02, FMT_INT), 32'h1);
    chk("busy cycles", 32'h4, busy_cycles - b);
    rdchk("clip flags", OFS_FLAGS, fl);
    for (int i = 0; i < 4; i++)
      peek("endpoint", i[4:0], q[32*i+:32]);
    peek("t", 5'h0A, 32'h2);
    peek("scratch", 5'h0B, ct);
  endtask
  task automatic t_irq();
    logic [31:0] s;
    apb(1'b1, OFS_MASK, 32'h0, s);
    apb(1'b1, OFS_CMD, word(CMP_REG_CLASS, CMP_OPC, 4'h5, 4'h6, 5'h0, 2'h0), s);
    s = 32'h0;
    for (int i = 0; i < 20 && s[0] !== 1'b1; i++)
      apb(1'b0, OFS_STAT, 32'h0, s);
    chk("irq stat", 32'h1, s);
    if (s !== 32'h1)
      end_sim();
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFS_MASK, 32'h1, s);
    rdchk("mask", OFS_MASK, 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, OFS_STAT, 32'h1, s);
    rdchk("stat", OFS_STAT, 32'h0);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask
  // reset, clear, compares, then clip both sign branches with whole-number t of 2, then irq
  initial
  begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    peek_sel = 5'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_clear();
    t_mem();
    t_clip({32'hA, 32'h7, 32'h3, 32'h5}, {32'hA, 32'h4, 32'h2, 32'h1},
      {32'hA, 32'hA, 32'h4, 32'h9}, 32'h4, 32'h0);
    t_clip({32'h5, 32'hFFFFFFFE, 32'h3, 32'h5}, {32'h3, 32'h3, 32'h2, 32'h1},
      {32'h7, 32'hFFFFFFF9, 32'h4, 32'h9}, 32'h8, 32'h4);
    t_irq();
    end_sim();
  end
endmodule
`default_nettype wire
